// File: include/pll_clock_gen_pkg.sv
// constants, types and state layout of the pll clock generator registers
package pll_clock_gen_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [1:0] PLL_CONTROL_IDX = 2'h0;
  localparam logic [1:0] PLL_BANDWIDTH_CONTROL_IDX = 2'h1;
  localparam logic [1:0] PLL_PROGRAMMING_IDX = 2'h2;
  // control register fields
  localparam int unsigned CTRL_IE_BIT = 7;
  localparam int unsigned CTRL_FLAG_BIT = 6;
  localparam int unsigned CTRL_ON_BIT = 5;
  localparam int unsigned CTRL_BCS_BIT = 4;
  localparam logic [3:0] CTRL_UNUSED_VAL = 4'hF;
  // bandwidth control register fields
  localparam int unsigned BW_AUTO_BIT = 7;
  localparam int unsigned BW_LOCK_BIT = 6;
  localparam int unsigned BW_ACQ_BIT = 5;
  localparam int unsigned BW_XLD_BIT = 4;
  localparam logic [3:0] BW_TEST_VAL = 4'h0;
  // programming register reset values and the multiplier driven for a zero field
  localparam logic [3:0] MUL_RESET = 4'h6;
  localparam logic [3:0] VRS_RESET = 4'h6;
  localparam logic [3:0] MUL_ZERO_AS = 4'h1;
  // source clock edges waited on each side during a switch
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  typedef enum logic {SW_STEADY, SW_HOLD} sw_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_s;

  typedef struct packed {
    logic irq_enable;
    logic lock_flag;
    logic power_on;
    logic base_sel;
    logic auto_bw;
    logic lock_q;
    logic acq_manual;
    logic xtal_loss;
    logic [3:0] mul;
    logic [3:0] vrs;
    logic sel_active;
    sw_state_e sw;
    logic [1:0] cnt_x;
    logic [1:0] cnt_v;
    logic xclk_prev;
    logic vclk_prev;
    logic base_q;
    logic ack;
    logic [7:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    irq_enable: 1'b0, lock_flag: 1'b0, power_on: 1'b1, base_sel: 1'b0,
    auto_bw: 1'b0, lock_q: 1'b0, acq_manual: 1'b0, xtal_loss: 1'b0,
    mul: MUL_RESET, vrs: VRS_RESET, sel_active: 1'b0, sw: SW_STEADY,
    cnt_x: 2'h0, cnt_v: 2'h0, xclk_prev: 1'b0, vclk_prev: 1'b0,
    base_q: 1'b0, ack: 1'b0, rdata: 8'h00};
endpackage

// File: verilog/pll_clock_gen_registers.sv
// register file and base clock selector of the pll clock generator
`timescale 1ns/1ps
`default_nettype none

// Operation
// - base clock is selected source divided by two, even duty cycle
// - irq enable ignores writes and reads zero in manual mode; reset clears it
// - lock flag sets on every lock toggle in auto mode; irq when flag and enable set in auto mode and stop is low
// - lock flag reads zero while manual mode is selected
// - a control register read that returns the flag set clears the lock flag; reset clears it
// - clearing pll power is refused while vco clock is selected
// - reset sets pll power on
// - base select refuses to set while pll power is off
// - switch waits three crystal edges and, while the vco runs, three vco edges, output held meanwhile
// - reset and stop clear base select back to crystal
// - four low control bits have no function and read ones
// - auto bit selects automatic bandwidth; reset selects manual
// - lock bit follows lock detector in auto, zero in manual, reset clears
// - filter bit reads tracking state in auto, stored value in manual; writable only in manual mode
// - manual filter value is kept through auto mode and restored
// - reset clears filter bit, acquisition mode
// - crystal loss test: write one, wait 4*N, read one if crystal dead
// - crystal loss works only with vco selected, else reads zero
// - multiplier writes blocked while pll power is on
// - vco range writes blocked while pll power on; reset six
module pll_clock_gen_registers (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire pll_clock_gen_pkg::avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_osc_enable_in,
  input wire logic i_stop,
  input wire logic i_crystal_clock,
  input wire logic i_vco_clock,
  input wire logic i_pll_locked,
  input wire logic i_filter_tracking,
  output logic o_crystal_clock,
  output logic o_base_clock_out,
  output logic o_pll_irq_out,
  output logic o_pll_enable,
  output logic o_auto_bw,
  output logic o_filter_track_manual,
  output logic [3:0] o_feedback_multiplier,
  output logic [3:0] o_vco_range_field
);
  import pll_clock_gen_pkg::*;

  state_s state_q;
  state_s state_d;

  logic vco_run;
  logic xclk;
  logic vclk;
  logic xrise;
  logic vrise;
  logic src_rise;
  logic lock_now;
  logic req;
  logic acc_rd;
  logic acc_wr;
  logic wr_ctrl;
  logic wr_bw;
  logic wr_prog;
  logic rd_ctrl;
  logic [7:0] wbyte;
  logic [7:0] rd_val;

  // oscillator enable gates everything; stop holds the outputs low
  assign vco_run = state_q.power_on && (state_q.vrs != 4'h0) &&
                   i_osc_enable_in && !i_stop;
  assign xclk = i_crystal_clock && i_osc_enable_in && !i_stop;
  assign vclk = i_vco_clock && vco_run;
  assign xrise = xclk && !state_q.xclk_prev;
  assign vrise = vclk && !state_q.vclk_prev;
  assign src_rise = state_q.sel_active ? vrise : xrise;
  // lock detector only counts in auto mode with the loop running
  assign lock_now = state_q.auto_bw && vco_run && i_pll_locked;

  assign req = i_avs.read || i_avs.write;
  assign acc_rd = i_avs.read && state_q.ack;
  assign acc_wr = i_avs.write && !i_avs.read && state_q.ack;
  assign wbyte = i_avs.writedata[7:0];
  assign wr_ctrl = acc_wr && i_avs.byteenable[0] &&
                   (i_avs.address == PLL_CONTROL_IDX);
  assign wr_bw = acc_wr && i_avs.byteenable[0] &&
                 (i_avs.address == PLL_BANDWIDTH_CONTROL_IDX);
  assign wr_prog = acc_wr && i_avs.byteenable[0] &&
                   (i_avs.address == PLL_PROGRAMMING_IDX);
  assign rd_ctrl = acc_rd && (i_avs.address == PLL_CONTROL_IDX);

  // read view of the addressed register
  always_comb begin
    rd_val = 8'h00;
    case (i_avs.address)
      PLL_CONTROL_IDX: begin
        rd_val[CTRL_IE_BIT] = state_q.auto_bw && state_q.irq_enable;
        rd_val[CTRL_FLAG_BIT] = state_q.auto_bw && state_q.lock_flag;
        rd_val[CTRL_ON_BIT] = state_q.power_on;
        rd_val[CTRL_BCS_BIT] = state_q.base_sel;
        rd_val[3:0] = CTRL_UNUSED_VAL;
      end
      PLL_BANDWIDTH_CONTROL_IDX: begin
        rd_val[BW_AUTO_BIT] = state_q.auto_bw;
        rd_val[BW_LOCK_BIT] = state_q.lock_q;
        rd_val[BW_ACQ_BIT] = state_q.auto_bw ? i_filter_tracking :
                             state_q.acq_manual;
        rd_val[BW_XLD_BIT] = state_q.base_sel && state_q.xtal_loss;
        rd_val[3:0] = BW_TEST_VAL;
      end
      PLL_PROGRAMMING_IDX: begin
        rd_val = {state_q.mul, state_q.vrs};
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    state_d.xclk_prev = xclk;
    state_d.vclk_prev = vclk;
    // one wait cycle per access, data captured in that cycle
    state_d.ack = req && !state_q.ack;
    if (req && !state_q.ack) begin
      state_d.rdata = rd_val;
    end

    // lock indicator and its change flag
    state_d.lock_q = lock_now;
    // clear only a flag value that the read actually returned
    if (rd_ctrl && state_q.rdata[CTRL_FLAG_BIT]) begin
      state_d.lock_flag = 1'b0;
    end
    if (state_q.auto_bw && (lock_now != state_q.lock_q)) begin
      state_d.lock_flag = 1'b1;
    end

    if (wr_ctrl) begin
      if (state_q.auto_bw) begin
        state_d.irq_enable = wbyte[CTRL_IE_BIT];
      end
      // interlock uses the current bits, so on and select need two writes
      if (wbyte[CTRL_ON_BIT] || !state_q.base_sel) begin
        state_d.power_on = wbyte[CTRL_ON_BIT];
      end
      if (!wbyte[CTRL_BCS_BIT]) begin
        state_d.base_sel = 1'b0;
      end else if (state_q.power_on && (state_q.vrs != 4'h0)) begin
        state_d.base_sel = 1'b1;
      end
    end

    if (wr_bw) begin
      state_d.auto_bw = wbyte[BW_AUTO_BIT];
      if (!state_q.auto_bw) begin
        state_d.acq_manual = wbyte[BW_ACQ_BIT];
      end
    end

    // crystal loss: a crystal edge clears it, a software one restarts it
    if (xrise) begin
      state_d.xtal_loss = 1'b0;
    end
    if (wr_bw) begin
      state_d.xtal_loss = wbyte[BW_XLD_BIT];
    end
    if (!state_q.base_sel) begin
      state_d.xtal_loss = 1'b0;
    end

    if (wr_prog && !state_q.power_on) begin
      state_d.mul = wbyte[7:4];
      state_d.vrs = wbyte[3:0];
    end

    if (state_q.vrs == 4'h0) begin
      state_d.base_sel = 1'b0;
    end

    // transition control and divide by two
    case (state_q.sw)
      SW_STEADY: begin
        if (src_rise) begin
          state_d.base_q = !state_q.base_q;
        end
        if (state_q.base_sel != state_q.sel_active) begin
          state_d.sw = SW_HOLD;
          state_d.cnt_x = 2'h0;
          state_d.cnt_v = 2'h0;
        end
      end
      SW_HOLD: begin
        // a dead vco cannot be waited on; its count is taken as met
        if (xrise && (state_q.cnt_x != SWITCH_EDGES)) begin
          state_d.cnt_x = state_q.cnt_x + 2'h1;
        end
        if (!vco_run) begin
          state_d.cnt_v = SWITCH_EDGES;
        end else if (vrise && (state_q.cnt_v != SWITCH_EDGES)) begin
          state_d.cnt_v = state_q.cnt_v + 2'h1;
        end
        if ((state_q.cnt_x == SWITCH_EDGES) &&
            (state_q.cnt_v == SWITCH_EDGES)) begin
          state_d.sel_active = state_q.base_sel;
          state_d.sw = SW_STEADY;
        end
      end
      default: begin
        state_d.sw = SW_STEADY;
      end
    endcase

    // stop returns to the crystal at once and holds the output low
    if (i_stop) begin
      state_d.base_sel = 1'b0;
      state_d.sel_active = 1'b0;
      state_d.sw = SW_STEADY;
      state_d.base_q = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= STATE_RESET;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // a frozen block must not let the master think its access landed
  assign o_avs_waitrequest = req && !(state_q.ack && i_ce);
  assign o_avs_readdata = {24'h000000, state_q.rdata};
  assign o_crystal_clock = xclk;
  assign o_base_clock_out = state_q.base_q;
  assign o_pll_irq_out = state_q.lock_flag && state_q.irq_enable &&
                         state_q.auto_bw && !i_stop;
  assign o_pll_enable = vco_run;
  assign o_auto_bw = state_q.auto_bw;
  assign o_filter_track_manual = state_q.acq_manual && !state_q.auto_bw;
  assign o_feedback_multiplier = (state_q.mul == 4'h0) ? MUL_ZERO_AS :
                                 state_q.mul;
  assign o_vco_range_field = state_q.vrs;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_flag_set;
    i_ce && state_q.auto_bw && (lock_now != state_q.lock_q) |=>
      state_q.lock_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("lock flag missed a lock toggle");

  property p_irq_manual;
    !state_q.auto_bw |-> !o_pll_irq_out;
  endproperty
  a_irq_manual: assert property (p_irq_manual)
    else $error("irq raised in manual mode");

  property p_flag_clear;
    i_ce && rd_ctrl && state_q.rdata[CTRL_FLAG_BIT] &&
      !(lock_now != state_q.lock_q) |=> !state_q.lock_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("control read did not clear lock flag");

  property p_on_held;
    state_q.base_sel && state_q.power_on |=> state_q.power_on;
  endproperty
  a_on_held: assert property (p_on_held)
    else $error("pll power cleared while vco selected");

  property p_sel_needs_on;
    !state_q.power_on && !state_q.base_sel |=> !state_q.base_sel;
  endproperty
  a_sel_needs_on: assert property (p_sel_needs_on)
    else $error("base select set with pll off");

  property p_stop_clear;
    i_ce && i_stop |=> !state_q.base_sel && !o_base_clock_out;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop did not clear base select");

  property p_unused_ones;
    acc_rd && (i_avs.address == PLL_CONTROL_IDX) |->
      o_avs_readdata[3:0] == 4'hF;
  endproperty
  a_unused_ones: assert property (p_unused_ones)
    else $error("unused control bits not read as ones");

  property p_prog_locked;
    state_q.power_on |=> $stable(state_q.mul) && $stable(state_q.vrs);
  endproperty
  a_prog_locked: assert property (p_prog_locked)
    else $error("programming field changed with pll on");

  property p_xld_zero;
    acc_rd && (i_avs.address == PLL_BANDWIDTH_CONTROL_IDX) &&
      !$past(state_q.base_sel) |-> !o_avs_readdata[BW_XLD_BIT];
  endproperty
  a_xld_zero: assert property (p_xld_zero)
    else $error("crystal loss read one with crystal selected");

  property p_hold_static;
    state_q.sw == SW_HOLD && !i_stop |=> $stable(state_q.base_q);
  endproperty
  a_hold_static: assert property (p_hold_static)
    else $error("base clock moved during source switch");

  property p_vrs_zero;
    state_q.vrs == 4'h0 |-> !o_pll_enable ##1 !state_q.base_sel;
  endproperty
  a_vrs_zero: assert property (p_vrs_zero)
    else $error("vco range zero left vco selectable");

  property p_wait_one;
    req && !state_q.ack && i_ce |=> !o_avs_waitrequest || !req;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus access not answered after one wait cycle");

  property p_ie_locked;
    wr_ctrl && !state_q.auto_bw |=> $stable(state_q.irq_enable);
  endproperty
  a_ie_locked: assert property (p_ie_locked)
    else $error("irq enable written in manual mode");

  property p_flag_manual;
    acc_rd && (i_avs.address == PLL_CONTROL_IDX) &&
      !$past(state_q.auto_bw) |-> !o_avs_readdata[CTRL_FLAG_BIT];
  endproperty
  a_flag_manual: assert property (p_flag_manual)
    else $error("lock flag read one in manual mode");

  property p_lock_manual;
    i_ce && !state_q.auto_bw |=> !state_q.lock_q;
  endproperty
  a_lock_manual: assert property (p_lock_manual)
    else $error("lock bit set in manual mode");

  property p_acq_kept;
    state_q.auto_bw |=> $stable(state_q.acq_manual);
  endproperty
  a_acq_kept: assert property (p_acq_kept)
    else $error("stored filter value changed in auto mode");

  property p_base_toggle;
    i_ce && !i_stop && (state_q.sw == SW_STEADY) && src_rise |=>
      $changed(o_base_clock_out);
  endproperty
  a_base_toggle: assert property (p_base_toggle)
    else $error("base clock missed a source edge");

  property p_gate_off;
    !i_osc_enable_in || i_stop |-> !o_pll_enable && !o_crystal_clock;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("clock ran with oscillator gated");

  c_flag: cover property (state_q.auto_bw ##1 state_q.lock_flag);
  c_to_vco: cover property (state_q.sw == SW_HOLD ##1
                            state_q.sw == SW_STEADY && state_q.sel_active);
  c_xld: cover property (acc_rd && o_avs_readdata[BW_XLD_BIT] &&
                         (i_avs.address == PLL_BANDWIDTH_CONTROL_IDX));
  c_irq: cover property (o_pll_irq_out);
endmodule // pll_clock_gen_registers

`default_nettype wire

// File: testbench/pll_clock_partner.sv
// crystal oscillator and vco model feeding the clock generator registers
`timescale 1ns/1ps
`default_nettype none
module pll_clock_partner #(
  parameter int XHALF = 8,
  parameter int VHALF = 3
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_osc_enable_in,
  input wire logic i_xtal_alive,
  input wire logic i_pll_enable,
  output logic o_crystal_clock,
  output logic o_vco_clock
);
  logic [3:0] xc_q, vc_q;
  // a dead or gated oscillator holds its level, it does not run free
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      xc_q <= 4'h0;
      vc_q <= 4'h0;
      o_crystal_clock <= 1'b0;
      o_vco_clock <= 1'b0;
    end else begin
      if (i_osc_enable_in && i_xtal_alive) begin
        xc_q <= (xc_q == 4'(XHALF - 1)) ? 4'h0 : xc_q + 4'h1;
        if (xc_q == 4'(XHALF - 1)) o_crystal_clock <= ~o_crystal_clock;
      end
      if (i_pll_enable) begin
        vc_q <= (vc_q == 4'(VHALF - 1)) ? 4'h0 : vc_q + 4'h1;
        if (vc_q == 4'(VHALF - 1)) o_vco_clock <= ~o_vco_clock;
      end
    end
  end
endmodule // pll_clock_partner
`default_nettype wire

// File: testbench/pll_clock_gen_registers_bench.sv
// self-checking bench for the pll clock generator registers
`timescale 1ns/1ps
`default_nettype none
module pll_clock_gen_registers_bench;
  import pll_clock_gen_pkg::*;
  logic i_clk, i_nrst, i_stop, i_osc_enable_in, i_pll_locked;
  logic i_filter_tracking, xtal_alive, xclk, vclk;
  avs_req_s avs;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_crystal_clock, o_base_clock_out, o_pll_irq_out;
  logic o_pll_enable, o_auto_bw, o_filter_track_manual;
  logic [3:0] o_feedback_multiplier, o_vco_range_field;
  logic [7:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int t, h;
  pll_clock_gen_registers dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_ce(1'b1), .i_avs(avs), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_osc_enable_in(i_osc_enable_in), .i_stop(i_stop),
    .i_crystal_clock(xclk), .i_vco_clock(vclk),
    .i_pll_locked(i_pll_locked), .i_filter_tracking(i_filter_tracking),
    .o_crystal_clock(o_crystal_clock), .o_base_clock_out(o_base_clock_out),
    .o_pll_irq_out(o_pll_irq_out), .o_pll_enable(o_pll_enable),
    .o_auto_bw(o_auto_bw), .o_filter_track_manual(o_filter_track_manual),
    .o_feedback_multiplier(o_feedback_multiplier),
    .o_vco_range_field(o_vco_range_field));
  pll_clock_partner far_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_osc_enable_in(i_osc_enable_in), .i_xtal_alive(xtal_alive),
    .i_pll_enable(o_pll_enable), .o_crystal_clock(xclk), .o_vco_clock(vclk));
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t pin got %b exp %b", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    avs.read <= !w;
    avs.write <= w;
    avs.address <= a;
    avs.writedata <= {24'h0, d};
    avs.byteenable <= 4'hF;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk_reg(q, exp);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // toggles of the base clock and high samples of the crystal pin
  task automatic tc(input int n);
    logic p;
    t = 0;
    h = 0;
    @(posedge i_clk);
    p = o_base_clock_out;
    repeat (n) begin
      @(posedge i_clk);
      if (o_base_clock_out !== p) t++;
      if (o_crystal_clock !== 1'b0) h++;
      p = o_base_clock_out;
    end
  endtask
  task automatic t_reset;
    rdchk(2'h0, 8'h2F);
    rdchk(2'h1, 8'h00);
    rdchk(2'h2, 8'h66);
    rdchk(2'h3, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_protect;
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h00);
    chk_pin(o_feedback_multiplier === 4'h1, 1'b1);
    wr(2'h0, 8'h20);
    wr(2'h0, 8'h30);
    rdchk(2'h0, 8'h2F);
    chk_pin(o_pll_enable, 1'b0);
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h63);
    wr(2'h0, 8'h30);
    rdchk(2'h0, 8'h2F);
    chk_pin(o_pll_enable, 1'b1);
    wr(2'h2, 8'h11);
    rdchk(2'h2, 8'h63);
    chk_pin(o_vco_range_field === 4'h3, 1'b1);
    $display("test protect done");
  endtask
  task automatic t_switch;
    tc(96);
    chk_pin(t inside {[5:7]}, 1'b1);
    wr(2'h0, 8'h30);
    tc(28);
    chk_pin(t == 0, 1'b1);
    wr(2'h0, 8'h10);
    rdchk(2'h0, 8'h3F);
    waitc(40);
    tc(96);
    chk_pin(t inside {[15:17]}, 1'b1);
    $display("test switch done");
  endtask
  task automatic t_xld;
    wr(2'h1, 8'h10);
    waitc(400);
    rdchk(2'h1, 8'h00);
    xtal_alive <= 1'b0;
    wr(2'h1, 8'h10);
    waitc(400);
    rdchk(2'h1, 8'h10);
    xtal_alive <= 1'b1;
    wr(2'h0, 8'h20);
    waitc(60);
    wr(2'h1, 8'h10);
    rdchk(2'h1, 8'h00);
    wr(2'h0, 8'h30);
    waitc(60);
    $display("test crystal loss done");
  endtask
  task automatic t_stop;
    i_stop <= 1'b1;
    tc(40);
    chk_pin(h == 0, 1'b1);
    chk_pin(o_base_clock_out, 1'b0);
    i_stop <= 1'b0;
    waitc(60);
    rdchk(2'h0, 8'h2F);
    tc(96);
    chk_pin(t inside {[5:7]}, 1'b1);
    $display("test stop done");
  endtask
  task automatic t_auto;
    wr(2'h0, 8'hA0);
    rdchk(2'h0, 8'h2F);
    i_pll_locked <= 1'b1;
    waitc(8);
    rdchk(2'h0, 8'h2F);
    rdchk(2'h1, 8'h00);
    wr(2'h1, 8'h20);
    rdchk(2'h1, 8'h20);
    chk_pin(o_filter_track_manual, 1'b1);
    i_filter_tracking <= 1'b1;
    wr(2'h1, 8'hA0);
    rdchk(2'h1, 8'hE0);
    chk_pin(o_auto_bw, 1'b1);
    chk_pin(o_filter_track_manual, 1'b0);
    waitc(8);
    bus(1'b0, 2'h0, 8'h00);
    wr(2'h0, 8'hA0);
    i_pll_locked <= 1'b0;
    waitc(8);
    chk_pin(o_pll_irq_out, 1'b1);
    rdchk(2'h0, 8'hEF);
    rdchk(2'h0, 8'hAF);
    chk_pin(o_pll_irq_out, 1'b0);
    wr(2'h1, 8'h00);
    rdchk(2'h1, 8'h20);
    $display("test auto done");
  endtask
  task automatic t_osc;
    i_osc_enable_in <= 1'b0;
    tc(40);
    chk_pin(h == 0, 1'b1);
    chk_pin(o_pll_enable, 1'b0);
    i_osc_enable_in <= 1'b1;
    $display("test oscillator enable done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    i_nrst = 1'b0;
    i_stop = 1'b0;
    i_osc_enable_in = 1'b1;
    i_pll_locked = 1'b0;
    i_filter_tracking = 1'b0;
    xtal_alive = 1'b1;
    avs = '0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_protect;
    t_switch;
    t_xld;
    t_stop;
    t_auto;
    t_osc;
    tally_and_finish;
  end
endmodule // pll_clock_gen_registers_bench
`default_nettype wire
